/* mmt_defs.vh */
// Constants for the multi-mode timer
`ifndef MMT_DEFS_VH
`define MMT_DEFS_VH
`define MMT_ADDR_CNT_HI 12'hf00
`define MMT_ADDR_CNT_LO 12'hf01
`define MMT_ADDR_RLD_HI 12'hf02
`define MMT_ADDR_RLD_LO 12'hf03
`define MMT_ADDR_PWM_HI 12'hf04
`define MMT_ADDR_PWM_LO 12'hf05
`define MMT_ADDR_CTRL 12'hf07
`define MMT_ADDR_IRQ_STAT 12'hf08
`define MMT_ADDR_IRQ_CLR 12'hf09
`define MMT_ADDR_IRQ_EN 12'hf0a
`define MMT_CTRL_EN 7
`define MMT_CTRL_POL 6
`define MMT_CTRL_CLOCK_DIVIDE_EXPONENT_HI 5
`define MMT_CTRL_CLOCK_DIVIDE_EXPONENT_LO 3
`define MMT_CTRL_MODE_HI 2
`define MMT_CTRL_MODE_LO 0
`define MMT_MODE_ONESHOT 3'h0
`define MMT_MODE_CONT 3'h1
`define MMT_MODE_COUNTER 3'h2
`define MMT_MODE_PWM 3'h3
`define MMT_MODE_CAPTURE 3'h4
`define MMT_MODE_COMPARE 3'h5
`define MMT_MODE_GATED 3'h6
`define MMT_MODE_CAPCMP 3'h7
`define MMT_IRQ_RELOAD 0
`define MMT_IRQ_CAPTURE 1
`define MMT_IRQ_GATE 2
`define MMT_CNT_RESTART 16'h0001
`define MMT_CNT_RESET 16'h0001
`define MMT_RLD_RESET 16'hffff
`endif

/* mmt_timer.v */
// Multi-mode 16-bit timer with byte register port and interrupt
// Functional notes
// - PWM restarts from 0001H after reload
// - Capture copies count into PWM pair
// - Capture polarity 0 rising, 1 falling
// - Compare output follows polarity, toggles on reload
// - Gated counts on level, interrupts on end
// - Capture/compare starts on first edge, captures later
// - Prescaler divides by two to the field
// - Prescaler cleared while timer disabled
// - Mode field selects eight modes
// - Count byte write loads counter half
// - Reload high held until low write
// - Compare mode matches against reload pair
// - DMA reload high write bypasses holding
// - Count is 16 bits, two readable bytes
`timescale 1ns/1ps
`default_nettype none
`include "mmt_defs.vh"
module mmt_timer (
  input wire I_CLK,
  input wire I_RSTN,
  input wire [11:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire I_DMA,
  output reg [7:0] O_RDATA,
  input wire I_TIN,
  output reg O_TOUT,
  output wire O_IRQ
);

  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [15:0] rld_reg;
  reg [15:0] rld_next;
  reg [7:0] hold_reg;
  reg [15:0] pwm_reg;
  reg [15:0] pwm_next;
  reg [7:0] ctrl_reg;
  reg [2:0] stat_reg;
  reg [2:0] stat_next;
  reg [2:0] irq_en_reg;
  reg [6:0] pre_reg;
  reg tin_d_reg;
  reg started_reg;
  reg started_next;
  reg tout_next;
  reg [2:0] ev;
  reg [7:0] rdata_next;

  wire en = ctrl_reg[`MMT_CTRL_EN];
  wire pol = ctrl_reg[`MMT_CTRL_POL];
  wire [2:0] clock_divide_exponent = ctrl_reg[`MMT_CTRL_CLOCK_DIVIDE_EXPONENT_HI:`MMT_CTRL_CLOCK_DIVIDE_EXPONENT_LO];
  wire [2:0] mode = ctrl_reg[`MMT_CTRL_MODE_HI:`MMT_CTRL_MODE_LO];
  wire rise = I_TIN & ~tin_d_reg;
  wire fall = ~I_TIN & tin_d_reg;
  // Polarity-selected input edge
  wire sel_edge = pol ? fall : rise;
  wire wr_cnt_hi = I_WR && (I_ADDR == `MMT_ADDR_CNT_HI);
  wire wr_cnt_lo = I_WR && (I_ADDR == `MMT_ADDR_CNT_LO);
  wire wr_clr = I_WR && (I_ADDR == `MMT_ADDR_IRQ_CLR);
  wire wr_ctrl = I_WR && (I_ADDR == `MMT_ADDR_CTRL);
  // Remaining register writes
  wire wr_rld_hi = I_WR && (I_ADDR == `MMT_ADDR_RLD_HI);
  wire wr_rld_lo = I_WR && (I_ADDR == `MMT_ADDR_RLD_LO);
  wire wr_pwm_hi = I_WR && (I_ADDR == `MMT_ADDR_PWM_HI);
  wire wr_pwm_lo = I_WR && (I_ADDR == `MMT_ADDR_PWM_LO);
  wire wr_ien = I_WR && (I_ADDR == `MMT_ADDR_IRQ_EN);
  // DMA bypasses the holding byte
  wire wr_rld_hi_dma = wr_rld_hi && I_DMA;
  wire wr_rld_hi_cpu = wr_rld_hi && !I_DMA;

  // Tick when the low prescaler bits are all ones
  function tick_of;
    input [2:0] p;
    input [6:0] c;
    reg [6:0] m;
    begin
      m = ~(7'h7f << p);
      tick_of = ((c & m) == m);
    end
  endfunction

  wire tick = en && tick_of(clock_divide_exponent, pre_reg);

  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      pre_reg <= 7'h00;
    end else if (!en) begin
      pre_reg <= 7'h00;
    end else begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // Next state of counter, capture and pin
  always @* begin
    cnt_next = cnt_reg;
    pwm_next = pwm_reg;
    tout_next = O_TOUT;
    started_next = started_reg;
    ev = 3'h0;
    if (!en) begin
      started_next = 1'b0;
      // Idle output level in compare and PWM
      if (mode == `MMT_MODE_COMPARE || mode == `MMT_MODE_PWM) begin
        tout_next = pol;
      end
    end else begin
      case (mode)
        `MMT_MODE_ONESHOT, `MMT_MODE_CONT: begin
          if (tick) begin
            if (cnt_reg == rld_reg) begin
              cnt_next = `MMT_CNT_RESTART;
              tout_next = ~O_TOUT;
              ev[`MMT_IRQ_RELOAD] = 1'b1;
            end else begin
              cnt_next = cnt_reg + 16'h0001;
            end
          end
        end
        `MMT_MODE_COUNTER: begin
          if (sel_edge) begin
            if (cnt_reg == rld_reg) begin
              cnt_next = `MMT_CNT_RESTART;
              tout_next = ~O_TOUT;
              ev[`MMT_IRQ_RELOAD] = 1'b1;
            end else begin
              cnt_next = cnt_reg + 16'h0001;
            end
          end
        end
        `MMT_MODE_PWM: begin
          if (tick) begin
            if (cnt_reg == rld_reg) begin
              cnt_next = `MMT_CNT_RESTART;
              tout_next = pol;
              ev[`MMT_IRQ_RELOAD] = 1'b1;
            end else begin
              cnt_next = cnt_reg + 16'h0001;
              if (cnt_reg == pwm_reg) begin
                tout_next = ~pol;
              end
            end
          end
        end
        `MMT_MODE_CAPTURE: begin
          if (sel_edge) begin
            pwm_next = cnt_reg;
            ev[`MMT_IRQ_CAPTURE] = 1'b1;
          end
          if (tick) begin
            if (cnt_reg == rld_reg) begin
              cnt_next = `MMT_CNT_RESTART;
              ev[`MMT_IRQ_RELOAD] = 1'b1;
            end else begin
              cnt_next = cnt_reg + 16'h0001;
            end
          end
        end
        `MMT_MODE_COMPARE: begin
          if (tick) begin
            if (cnt_reg == rld_reg) begin
              cnt_next = `MMT_CNT_RESTART;
              tout_next = ~O_TOUT;
              ev[`MMT_IRQ_RELOAD] = 1'b1;
            end else begin
              cnt_next = cnt_reg + 16'h0001;
            end
          end
        end
        `MMT_MODE_GATED: begin
          if (pol ? rise : fall) begin
            ev[`MMT_IRQ_GATE] = 1'b1;
          end
          if (tick && (I_TIN != pol)) begin
            if (cnt_reg == rld_reg) begin
              cnt_next = `MMT_CNT_RESTART;
              ev[`MMT_IRQ_RELOAD] = 1'b1;
            end else begin
              cnt_next = cnt_reg + 16'h0001;
            end
          end
        end
        default: begin
          if (sel_edge) begin
            if (!started_reg) begin
              started_next = 1'b1;
            end else begin
              pwm_next = cnt_reg;
              ev[`MMT_IRQ_CAPTURE] = 1'b1;
            end
          end
          if (tick && started_reg) begin
            if (cnt_reg == rld_reg) begin
              cnt_next = `MMT_CNT_RESTART;
              ev[`MMT_IRQ_RELOAD] = 1'b1;
            end else begin
              cnt_next = cnt_reg + 16'h0001;
            end
          end
        end
      endcase
      if (mode == `MMT_MODE_ONESHOT && ev[`MMT_IRQ_RELOAD]) begin
        started_next = 1'b0;
      end
    end
    if (wr_cnt_hi) begin
      cnt_next[15:8] = I_WDATA;
    end
    if (wr_cnt_lo) begin
      cnt_next[7:0] = I_WDATA;
    end
    if (wr_pwm_hi) begin
      pwm_next[15:8] = I_WDATA;
    end
    if (wr_pwm_lo) begin
      pwm_next[7:0] = I_WDATA;
    end
  end

  // Sticky status, set wins over clear
  always @* begin
    stat_next = (stat_reg & ~({3{wr_clr}} & I_WDATA[2:0])) | ev;
  end

  always @* begin
    rld_next = rld_reg;
    if (wr_rld_hi_dma) begin
      rld_next[15:8] = I_WDATA;
    end
    if (wr_rld_lo) begin
      rld_next = {hold_reg, I_WDATA};
    end
  end

  wire oneshot_stop = en && mode == `MMT_MODE_ONESHOT &&
    ev[`MMT_IRQ_RELOAD];

  // Counter, capture and status
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      cnt_reg <= `MMT_CNT_RESET;
      pwm_reg <= 16'h0000;
      stat_reg <= 3'h0;
      started_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pwm_reg <= pwm_next;
      stat_reg <= stat_next;
      started_reg <= started_next;
    end
  end

  // Reload value and its holding byte
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      rld_reg <= `MMT_RLD_RESET;
      hold_reg <= 8'h00;
    end else begin
      rld_reg <= rld_next;
      if (wr_rld_hi_cpu) begin
        hold_reg <= I_WDATA;
      end
    end
  end

  // Control; one-shot drops enable at reload
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      ctrl_reg <= 8'h00;
    end else if (wr_ctrl) begin
      ctrl_reg <= I_WDATA;
    end else if (oneshot_stop) begin
      ctrl_reg[`MMT_CTRL_EN] <= 1'b0;
    end
  end

  // Interrupt enable mask
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      irq_en_reg <= 3'h0;
    end else if (wr_ien) begin
      irq_en_reg <= I_WDATA[2:0];
    end
  end

  // Pin sampling and output level
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      tin_d_reg <= 1'b0;
      O_TOUT <= 1'b0;
    end else begin
      tin_d_reg <= I_TIN;
      O_TOUT <= tout_next;
    end
  end

  // Read mux, data stands one cycle
  always @* begin
    if (!I_RD) begin
      rdata_next = 8'h00;
    end else if (I_ADDR == `MMT_ADDR_CNT_HI) begin
      rdata_next = cnt_reg[15:8];
    end else if (I_ADDR == `MMT_ADDR_CNT_LO) begin
      rdata_next = cnt_reg[7:0];
    end else if (I_ADDR == `MMT_ADDR_RLD_HI) begin
      rdata_next = rld_reg[15:8];
    end else if (I_ADDR == `MMT_ADDR_RLD_LO) begin
      rdata_next = rld_reg[7:0];
    end else if (I_ADDR == `MMT_ADDR_PWM_HI) begin
      rdata_next = pwm_reg[15:8];
    end else if (I_ADDR == `MMT_ADDR_PWM_LO) begin
      rdata_next = pwm_reg[7:0];
    end else if (I_ADDR == `MMT_ADDR_CTRL) begin
      rdata_next = ctrl_reg;
    end else if (I_ADDR == `MMT_ADDR_IRQ_STAT) begin
      rdata_next = {5'h00, stat_reg};
    end else if (I_ADDR == `MMT_ADDR_IRQ_EN) begin
      rdata_next = {5'h00, irq_en_reg};
    end else begin
      rdata_next = 8'h00;
    end
  end

  // Read data register
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= rdata_next;
    end
  end

  assign O_IRQ = |(stat_reg & irq_en_reg);

endmodule
`default_nettype wire

/* mmt_assertions.sv */
// Port checker for the multi-mode timer
`timescale 1ns/1ps
`default_nettype none
`include "mmt_defs.vh"
module mmt_assertions (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic [11:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_DMA,
  input wire logic [7:0] O_RDATA,
  input wire logic I_TIN,
  input wire logic O_TOUT,
  input wire logic O_IRQ
);
  logic [2:0] mode_q;
  logic [2:0] ien_q;
  logic en_q;
  wire ctl_wr = I_WR && I_ADDR == `MMT_ADDR_CTRL;
  wire pol_w = I_WDATA[6];
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // Shadow of control and interrupt enable
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      mode_q <= 3'h0;
      en_q <= 1'b0;
      ien_q <= 3'h0;
    end else begin
      if (ctl_wr) begin
        mode_q <= I_WDATA[2:0];
        en_q <= I_WDATA[7];
      end
      if (I_WR && I_ADDR == `MMT_ADDR_IRQ_EN) ien_q <= I_WDATA[2:0];
    end
  end
  AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("rdata not idle");
  AST_RD_UNMAPPED: assert property ($past(I_RD) && $past(I_ADDR) == 12'hf06
    |-> O_RDATA == 8'h00) else $error("unmapped read data");
  AST_RESET_OUT: assert property ($rose(I_RSTN) |-> !O_TOUT && !O_IRQ)
    else $error("outputs after reset");
  AST_CMP_IDLE: assert property (
    ctl_wr && !I_WDATA[7] && I_WDATA[2:0] == `MMT_MODE_COMPARE
    |=> ##1 O_TOUT == $past(pol_w, 2)) else $error("idle compare level");
  AST_TOUT_STILL: assert property (
    !en_q && !$past(en_q) && !$past(ctl_wr) && !$past(ctl_wr, 2)
    |-> $stable(O_TOUT)) else $error("output moved while off");
  AST_TOUT_IRQ: assert property (
    (mode_q == `MMT_MODE_CONT || mode_q == `MMT_MODE_COMPARE) && en_q
    && $past(en_q) && ien_q[0] && $changed(O_TOUT) |-> O_IRQ)
    else $error("toggle without irq");
  AST_IRQ_FALL: assert property ($fell(O_IRQ) |-> $past(I_WR) &&
    ($past(I_ADDR) == `MMT_ADDR_IRQ_CLR || $past(I_ADDR) == `MMT_ADDR_IRQ_EN))
    else $error("irq dropped");
  AST_IRQ_RISE: assert property ($rose(O_IRQ) |-> ien_q != 3'h0)
    else $error("irq while masked");
endmodule
bind mmt_timer mmt_assertions u_chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .I_DMA(I_DMA), .O_RDATA(O_RDATA), .I_TIN(I_TIN), .O_TOUT(O_TOUT),
  .O_IRQ(O_IRQ));
`default_nettype wire

/* mmt_pin_model.sv */
// Timer input pin driver
`timescale 1ns/1ps
`default_nettype none
module mmt_pin_model (
  input wire logic i_clk,
  input wire logic i_level,
  output logic o_tin
);
  // Level moves just after an edge, held a cycle at least
  always @(posedge i_clk) o_tin <= i_level;
endmodule
`default_nettype wire

/* mmt_timer_bench.sv */
// Self-checking bench for the multi-mode timer
`timescale 1ns/1ps
`default_nettype none
`include "mmt_defs.vh"
module mmt_timer_bench;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, dma = 0, lvl = 0;
  logic [11:0] addr = 0;
  logic [7:0] wdata = 0, d, hold;
  logic [7:0] regs [16];
  wire [7:0] rdata;
  wire tin, tout, irq;
  int errors = 0, compares = 0, i, k, n, r, p;
  always #10 clk = ~clk;
  mmt_pin_model pin (.i_clk(clk), .i_level(lvl), .o_tin(tin));
  mmt_timer uut (.I_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .I_DMA(dma), .O_RDATA(rdata), .I_TIN(tin),
    .O_TOUT(tout), .O_IRQ(irq));
  task finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input string s, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task wr8(input logic [11:0] a, input logic [7:0] v, input logic m);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    dma <= m;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    if (a == `MMT_ADDR_RLD_HI && !m) hold = v;
    else if (a != `MMT_ADDR_IRQ_STAT) regs[a[3:0]] = v;
    if (a == `MMT_ADDR_RLD_LO) regs[2] = hold;
    if (a == `MMT_ADDR_IRQ_CLR) regs[8] = regs[8] & ~v;
  endtask
  task chk(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp("rdata", {8'h00, regs[a[3:0]]}, {8'h00, rdata});
  endtask
  task wchg(output int c);
    logic t;
    t = tout;
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (tout === t && c < 3000);
  endtask
  task run(input logic [2:0] m, input logic pl, input logic [2:0] ps,
    input logic [7:0] rl, input logic [7:0] pw);
    wr8(`MMT_ADDR_CTRL, {1'b0, pl, ps, m}, 1'b0);
    wr8(`MMT_ADDR_IRQ_CLR, 8'h07, 1'b0);
    wr8(`MMT_ADDR_CNT_HI, 8'h00, 1'b0);
    wr8(`MMT_ADDR_CNT_LO, rl, 1'b0);
    wr8(`MMT_ADDR_PWM_LO, pw, 1'b0);
    wr8(`MMT_ADDR_RLD_HI, {8{m == `MMT_MODE_CAPTURE}}, 1'b0);
    wr8(`MMT_ADDR_RLD_LO, rl, 1'b0);
    wr8(`MMT_ADDR_CTRL, {1'b1, pl, ps, m}, 1'b0);
  endtask
  initial begin
    #400000;
    errors++;
    finish_test;
  end
  initial begin
    regs = '{default: 8'h00};
    regs[1] = 8'h01;
    regs[2] = 8'hff;
    regs[3] = 8'hff;
    void'($urandom(32'hdc14));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 11; i++) if (i != 9) chk(12'hf00 + 12'(i));
    wr8(`MMT_ADDR_IRQ_STAT, 8'hff, 1'b0);
    chk(`MMT_ADDR_IRQ_STAT);
    wr8(`MMT_ADDR_RLD_HI, 8'h12, 1'b0);
    chk(`MMT_ADDR_RLD_HI);
    wr8(`MMT_ADDR_RLD_LO, 8'h34, 1'b0);
    chk(`MMT_ADDR_RLD_HI);
    wr8(`MMT_ADDR_RLD_HI, 8'h56, 1'b1);
    chk(`MMT_ADDR_RLD_HI);
    wr8(`MMT_ADDR_CNT_HI, 8'($urandom), 1'b0);
    chk(`MMT_ADDR_CNT_HI);
    wr8(`MMT_ADDR_IRQ_EN, 8'h01, 1'b0);
    for (k = 0; k < 4; k++) begin
      r = 2 + $urandom % 5;
      p = $urandom % 4;
      run(k[1] ? `MMT_MODE_COMPARE : `MMT_MODE_CONT, k[0], 3'(p), 8'(r), 0);
      wchg(n);
      wchg(n);
      cmp("period", 16'(r << p), 16'(n));
    end
    cmp("irq", 16'h0001, {15'h0000, irq});
    wr8(`MMT_ADDR_IRQ_EN, 8'h00, 1'b0);
    cmp("irq", 16'h0000, {15'h0000, irq});
    for (k = 0; k < 2; k++) begin
      p = 1 + $urandom % 5;
      r = p + 2 + $urandom % 5;
      run(`MMT_MODE_PWM, k[0], 3'h0, 8'(r), 8'(p));
      do wchg(n); while (tout !== 1'b0);
      wchg(n);
      wchg(n);
      cmp("high", 16'(k ? p : r - p), 16'(n));
    end
    for (k = 0; k < 2; k++) begin
      lvl <= k[0];
      run(`MMT_MODE_CAPTURE, k[0], 3'h0, 8'h01, 8'h00);
      lvl <= !k[0];
      repeat (2) @(posedge clk);
      regs[8] = 8'h02;
      chk(`MMT_ADDR_IRQ_STAT);
      wr8(`MMT_ADDR_IRQ_CLR, 8'h07, 1'b0);
      lvl <= k[0];
      chk(`MMT_ADDR_IRQ_STAT);
    end
    lvl <= 1'b1;
    run(`MMT_MODE_GATED, 1'b0, 3'h0, 8'h40, 8'h00);
    lvl <= 1'b0;
    repeat (2) @(posedge clk);
    regs[8] = 8'h05;
    chk(`MMT_ADDR_IRQ_STAT);
    finish_test;
  end
endmodule
`default_nettype wire
